/* design/rfb_buf.sv */
`timescale 1ns/1ps
`include "rfb_cfg.svh"

module rfb_buf
    import rfb_pkg::*;
(
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    // fill side
    input  wire logic      in_valid_i,
    output logic           in_ready_o,
    input  wire rfb_word_t in_data_i,
    // drain side
    output logic           out_valid_o,
    input  wire logic      out_ready_i,
    output rfb_word_t      out_data_o
);

    rfb_word_t mem_q [`RFB_BUF_DEPTH];
    rfb_word_t mem_d [`RFB_BUF_DEPTH];
    logic      wr_q;
    logic      wr_d;
    logic      rd_q;
    logic      rd_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic      push;
    logic      pop;

    ////////////////////////////////////////////////////////////////////////
    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];

    always_comb
    begin
        push  = in_valid_i && in_ready_o;
        pop   = out_valid_o && out_ready_i;
        mem_d = mem_q;
        if (push)
        begin
            mem_d[wr_q] = in_data_i;
        end
        wr_d  = push ? ~wr_q : wr_q;
        rd_d  = pop ? ~rd_q : rd_q;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    // reset empties the buffer so no stale word reaches the outputs
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mem_q <= '{default: '0};
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule

/* design/rfb_cfg.svh */
`ifndef RFB_CFG_SVH
`define RFB_CFG_SVH

`define RFB_IN_W      13
`define RFB_OUT_W     26
`define RFB_BUF_DEPTH 2
`define RFB_CLK_NS    20
`define RFB_ACT_NS    22
`define RFB_ACT_CYC   ((`RFB_ACT_NS + `RFB_CLK_NS - 1) / `RFB_CLK_NS)
`define RFB_CNT_W     2

`endif

/* design/rfb_pkg.sv */
`include "rfb_cfg.svh"

package rfb_pkg;

    typedef logic [`RFB_IN_W-1:0]  rfb_word_t;
    typedef logic [`RFB_OUT_W-1:0] rfb_wide_t;
    typedef logic [`RFB_CNT_W-1:0] rfb_cnt_t;

    typedef enum logic [1:0]
    {
        RFB_WAKE = 2'b01,
        RFB_RUN  = 2'b10
    } rfb_state_t;

endpackage

/* design/rfb_top.sv */
`timescale 1ns/1ps
`include "rfb_cfg.svh"

module rfb_top
    import rfb_pkg::*;
(
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    // differential capture clock, sampled as data
    input  wire logic      cap_clk_t_i,
    input  wire logic      cap_clk_c_i,
    // captured input bits
    input  wire rfb_word_t captured_input_bits_i,
    output logic           in_ready_o,
    // registered output bits, two copies per input bit
    output rfb_wide_t      registered_output_bits_o,
    output logic           out_valid_o,
    input  wire logic      out_ready_i,
    // status
    output logic           rx_enabled_o
);

    ////////////////////////////////////////////////////////////////////////
    // each input bit drives outputs 2k and 2k+1
    function automatic rfb_wide_t dup(input rfb_word_t w);
        rfb_wide_t r;
        r = '0;
        for (int k = 0; k < `RFB_IN_W; k++)
        begin
            r[2*k]   = w[k];
            r[2*k+1] = w[k];
        end
        return r;
    endfunction

    rfb_state_t state_q;
    rfb_state_t state_d;
    rfb_cnt_t   cnt_q;
    rfb_cnt_t   cnt_d;
    logic       t_prev_q;
    logic       t_prev_d;
    logic       c_prev_q;
    logic       c_prev_d;
    logic       rx_en_q;
    logic       rx_en_d;
    logic       crossing;
    logic       cap_valid;
    logic       buf_ready;
    logic       buf_valid;
    rfb_word_t  buf_data;
    rfb_wide_t  out_q;
    rfb_wide_t  out_d;
    logic       ov_q;
    logic       ov_d;
    logic       ir_q;
    logic       ir_d;

    ////////////////////////////////////////////////////////////////////////
    // receiver wake-up: inputs ignored for the activation time after
    // release, so a controller that is late to drive data low cannot
    // leak a high onto the outputs
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        rx_en_d = rx_en_q;
        unique case (state_q)
            RFB_WAKE:
            begin
                cnt_d = cnt_q + rfb_cnt_t'(1);
                if (cnt_q == rfb_cnt_t'(`RFB_ACT_CYC - 1))
                begin
                    state_d = RFB_RUN;
                    rx_en_d = 1'b1;
                end
            end
            RFB_RUN:
            begin
                rx_en_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= RFB_WAKE;
            cnt_q   <= '0;
            rx_en_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            rx_en_q <= rx_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossing detect: true goes low to high while complement goes high
    // to low between two samples; the pair is sampled while waking too,
    // so a pin parked high is not seen as an edge once receivers come on
    always_comb
    begin
        t_prev_d  = cap_clk_t_i;
        c_prev_d  = cap_clk_c_i;
        crossing  = rx_en_q && !t_prev_q && c_prev_q
                    && cap_clk_t_i && !cap_clk_c_i;
        cap_valid = crossing;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            t_prev_q <= 1'b0;
            c_prev_q <= 1'b1;
        end
        else
        begin
            t_prev_q <= t_prev_d;
            c_prev_q <= c_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry buffer; a word captured while it is full is lost; in_ready_o
    // is buf_ready registered, so it goes low one cycle after the buffer fills
    rfb_buf u_buf
    (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (cap_valid),
        .in_ready_o  (buf_ready),
        .in_data_i   (captured_input_bits_i),
        .out_valid_o (buf_valid),
        .out_ready_i (out_ready_i),
        .out_data_o  (buf_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // output stage
    always_comb
    begin
        out_d = out_q;
        ov_d  = 1'b0;
        ir_d  = buf_ready;
        if (buf_valid && out_ready_i)
        begin
            out_d = dup(buf_data);
            ov_d  = 1'b1;
        end
    end

    // outputs cleared with the state, no clock needed
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            out_q <= '0;
            ov_q  <= 1'b0;
            ir_q  <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
            ov_q  <= ov_d;
            ir_q  <= ir_d;
        end
    end

    assign registered_output_bits_o = out_q;
    assign out_valid_o              = ov_q;
    assign in_ready_o               = ir_q;
    assign rx_enabled_o             = rx_en_q;

endmodule

/* testbench/registered_fanout_buffer_13x2_test.sv */
`timescale 1ns/1ps
module registered_fanout_buffer_13x2_test;
    import rfb_pkg::*;
    logic      clk_i, rst_n_i, run, out_ready_i, in_ready_o, out_valid_o;
    logic      t, c, rx_enabled_o;
    rfb_word_t word, data, w;
    rfb_wide_t outs, exp;
    int        failures = 0;
    int        n_tests = 0;
    rfb_ctl_model rfb_ctl_model_inst (.clk_i, .rst_n_i, .run_i(run),
        .word_i(word), .cap_clk_t_o(t), .cap_clk_c_o(c), .data_o(data));
    rfb_top rfb_top_inst (.clk_i, .rst_n_i, .cap_clk_t_i(t),
        .cap_clk_c_i(c), .captured_input_bits_i(data), .in_ready_o,
        .registered_output_bits_o(outs), .out_valid_o, .out_ready_i,
        .rx_enabled_o);
    ////////////////////////////////////////////////////////////////////
    function automatic rfb_wide_t dup(rfb_word_t v);
        rfb_wide_t d;
        for (int k = 0; k < 13; k++) d[2*k+:2] = {2{v[k]}};
        return d;
    endfunction
    task automatic check(rfb_wide_t seen, rfb_wide_t want);
        n_tests++;
        if (seen !== want)
        begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic idle_low(int n);
        repeat (n)
        begin
            @(negedge clk_i);
            check(outs, '0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 0;
        forever #10 clk_i = !clk_i;
    end
    initial
    begin
        #200000 failures++;
        give_verdict();
    end
    initial
    begin
        {rst_n_i, run, word} = '0;
        out_ready_i = 1;
        void'($urandom(32'h2277));
        repeat (6) @(negedge clk_i);
        check(outs, '0);
        run = 1;
        rst_n_i = 1;
        idle_low(8);
        check(rx_enabled_o, 1);
        for (int i = 0; i < 24; i++)
        begin
            word = (i == 0) ? 13'h1fff : (i == 1) ? 13'h0aaa
                 : rfb_word_t'($urandom);
            repeat (8) @(negedge clk_i);
            check(outs, dup(word));
        end
        // stopped pair: data moves, outputs must not
        // stop first, change data one cycle later, so a last toggle
        // racing the stop can only capture the old word
        run = 0;
        w = word;
        @(negedge clk_i);
        word = ~word;
        repeat (8) @(negedge clk_i);
        check(outs, dup(w));
        run = 1;
        repeat (8) @(negedge clk_i);
        check(outs, dup(word));
        // stall fills the buffer, later captures are dropped, new word out on resume
        out_ready_i = 0;
        exp = dup(word);
        word = rfb_word_t'($urandom);
        repeat (10) @(negedge clk_i);
        check(outs, exp);
        check(in_ready_o, 0);
        check(out_valid_o, 0);
        out_ready_i = 1;
        repeat (8) @(negedge clk_i);
        check(outs, dup(word));
        // reset mid-run, checked before any clock edge
        #2 rst_n_i = 0;
        #1 check(outs, '0);
        check(rx_enabled_o, 0);
        word = 0;
        repeat (3) @(negedge clk_i);
        rst_n_i = 1;
        idle_low(6);
        give_verdict();
    end
endmodule
bind rfb_top rfb_checker rfb_checker_inst (.clk_i, .rst_n_i, .out_ready_i,
    .in_ready_o, .out_valid_o, .rx_enabled_o, .registered_output_bits_o);

/* testbench/rfb_checker.sv */
`timescale 1ns/1ps
module rfb_checker
    import rfb_pkg::*;
(
    input wire logic      clk_i,
    input wire logic      rst_n_i,
    input wire logic      out_ready_i,
    input wire logic      in_ready_o,
    input wire logic      out_valid_o,
    input wire logic      rx_enabled_o,
    input wire rfb_wide_t registered_output_bits_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wake;
        !rx_enabled_o [*2] ##1 rx_enabled_o;
    endsequence
    a_copy_pair:
    assert property ((registered_output_bits_o & 26'h2aaaaaa) >> 1
        == (registered_output_bits_o & 26'h1555555)) else $error("copy");
    a_reset_clear:
    assert property (disable iff (1'b0) !rst_n_i |->
        registered_output_bits_o == '0 && !rx_enabled_o && !out_valid_o
        && !in_ready_o) else $error("reset");
    a_release_low:
    assert property ($rose(rst_n_i) |->
        (registered_output_bits_o == '0) [*4]) else $error("release");
    a_wake_delay:
    assert property ($rose(rst_n_i) |-> s_wake) else $error("wake");
    a_out_hold:
    assert property (!out_valid_o |-> $stable(registered_output_bits_o))
        else $error("hold");
    a_drain_ready:
    assert property (out_valid_o |-> $past(out_ready_i)) else $error("ready");
    a_load_woken:
    assert property (out_valid_o |-> $past(rx_enabled_o, 2))
        else $error("load");
endmodule

/* testbench/rfb_ctl_model.sv */
`timescale 1ns/1ps
module rfb_ctl_model
    import rfb_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire logic      run_i,
    input  wire rfb_word_t word_i,
    output logic           cap_clk_t_o,
    output logic           cap_clk_c_o,
    output rfb_word_t      data_o
);
    logic [1:0] wait_q;
    // pair stands at t=0 c=1 in reset and holds its last level while stopped
    always @(negedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_q      <= 2'h0;
            cap_clk_t_o <= 1'b0;
        end
        else
        begin
            if (wait_q != 2'h3) wait_q <= wait_q + 2'h1;
            if (run_i) cap_clk_t_o <= !cap_clk_t_o;
        end
    end
    assign cap_clk_c_o = !cap_clk_t_o;
    // data low past activation time, 3 cycles covers 22 ns
    assign data_o = (wait_q == 2'h3) ? word_i : '0;
endmodule
